// ---- rtl/pmti_defs.svh ----
// Purpose: Shared constants of the PMBus target interface
// Assumes: Included by bare name wherever codes or timings are needed
// Notes:   Codes are command bytes; positions are bit indexes
`ifndef PMTI_DEFS_SVH
`define PMTI_DEFS_SVH
// Command codes
`define PMTI_CMD_CLEAR   8'h03
`define PMTI_CMD_STORE   8'h15
`define PMTI_CMD_RESTORE 8'h16
`define PMTI_CMD_MASK    8'h1b
`define PMTI_CMD_STAT_B  8'h78
`define PMTI_CMD_STAT_W  8'h79
`define PMTI_CMD_VIN     8'h88
`define PMTI_CMD_VOUT    8'h8b
`define PMTI_CMD_IOUT    8'h8c
`define PMTI_CMD_TEMP    8'h8d
`define PMTI_CMD_DUTY    8'h94
`define PMTI_CMD_FREQ    8'h95
`define PMTI_CMD_OFFSET  8'hc9
`define PMTI_CMD_TSEL    8'hdc
// Address resolution
`define PMTI_STRAP_MULT  9'h008
`define PMTI_ADDR_MIN    9'h001
`define PMTI_ADDR_MAX    9'h07e
`define PMTI_ADDR_BAD0   9'h00c
`define PMTI_ADDR_BAD1   9'h010
`define PMTI_ADDR_FALLBK 7'h7e
// Field positions, reset values and config depth
`define PMTI_BUSY_BIT    7
`define PMTI_FAULT_BIT   0
`define PMTI_TSEL_BIT    0
`define PMTI_CFG_RST     16'h0000
`define PMTI_OFFSET_RST  8'h00
`define PMTI_CFG_DEPTH   256
// Timing
`define PMTI_STORE_MS    5
`define PMTI_REF_KHZ     20000
`endif

// ---- rtl/pmti_hs.sv ----
// Purpose: Toggle handshake carrying one word between clock domains
// Assumes: Source offers a word only while not busy
// Notes:   Word held stable until the return toggle arrives
module pmti_hs #(
	parameter int W = 8
) (
	// Source side
	input  wire logic         s_clk,
	input  wire logic         s_rst,
	input  wire logic         s_valid,
	input  wire logic [W-1:0] s_data,
	output logic              s_busy,
	// Destination side
	input  wire logic         d_clk,
	input  wire logic         d_rst,
	output logic              d_pulse,
	output logic [W-1:0]      d_data
);
	logic         tog_reg;
	logic [W-1:0] hold_reg;
	logic         ack_s;
	logic         tog_s;
	logic         seen_reg;
	if (W < 1) begin : g_chk
		$error("pmti_hs width must be positive");
	end
	// Launch a word and flip the toggle
	always_ff @(posedge s_clk) begin
		if (s_rst) begin
			tog_reg  <= 1'b0;
			hold_reg <= '0;
		end else if (s_valid && !s_busy) begin
			tog_reg  <= ~tog_reg;
			hold_reg <= s_data;
		end
	end
	assign s_busy = tog_reg ^ ack_s;
	pmti_sync #(.W(1)) u_tog (.clk(d_clk), .d(tog_reg), .q(tog_s));
	// Capture the held word when the toggle moves
	always_ff @(posedge d_clk) begin
		if (d_rst) begin
			seen_reg <= 1'b0;
			d_pulse  <= 1'b0;
			d_data   <= '0;
		end else begin
			seen_reg <= tog_s;
			d_pulse  <= tog_s ^ seen_reg;
			if (tog_s ^ seen_reg) begin
				d_data <= hold_reg;
			end
		end
	end
	pmti_sync #(.W(1)) u_ack (.clk(s_clk), .d(seen_reg), .q(ack_s));
endmodule : pmti_hs

// ---- rtl/pmti_pkg.sv ----
// Purpose: Types of the PMBus target interface
// Assumes: Nothing beyond the language
// Notes:   Constants live in the defs header
package pmti_pkg;
	typedef logic [7:0]  pmti_byte_t;
	typedef logic [15:0] pmti_word_t;
	// Link-side protocol states
	typedef enum logic [3:0] {
		LS_IDLE, LS_ADDR, LS_WRX, LS_WACK, LS_WAIT,
		LS_REL, LS_TX, LS_RACK, LS_SKIP
	} pmti_lst_e;
endpackage : pmti_pkg

// ---- rtl/pmti_sync.sv ----
// Purpose: Two-stage synchroniser for levels
// Assumes: Input is a level, or bits that change one at a time
// Notes:   No reset; settles two clocks after power-up
module pmti_sync #(
	parameter int W = 1
) (
	// Clock
	input  wire logic         clk,
	// Data
	input  wire logic [W-1:0] d,
	output logic [W-1:0]      q
);
	logic [W-1:0] meta_reg;
	if (W < 1) begin : g_chk
		$error("pmti_sync width must be positive");
	end
	// First stage feeds second stage only
	always_ff @(posedge clk) begin
		meta_reg <= d;
		q        <= meta_reg;
	end
endmodule : pmti_sync

// ---- rtl/pmti_target.sv ----
// Purpose: PMBus target: bus engine, address resolve, config, alert
// Assumes: LINK_CLK oversamples the bus; RST is on REF_CLK
// Notes:   Reads stretch SCL until the reply crosses back
// Functional notes
// - Target stretches SCL; host waits it out
// - Command and transaction formats per PMBus 1.3
// - Standard SMBus protocols including stretching
// - Address is eight times high plus low
// - Base offset added from config command 0xC9
// - Valid addresses 1 to 126, not 12, 16
// - Invalid address falls back to 126
// - Status busy flag while occupied
// - Alert pin driven on protection fault
// - Telemetry reads answered at any time
// - Temperature read follows 0xDC sensor select
// - Config in memory, all settings rewritable
// - Alert held until clear or re-enable
// - Alert mask command gates fault sources
// - Store command copies working config to user memory
`include "pmti_defs.svh"
module pmti_target #(
	parameter int         STORE_CYC  = `PMTI_STORE_MS * `PMTI_REF_KHZ,
	parameter logic [7:0] DEF_OFFSET = `PMTI_OFFSET_RST
) (
	// Clocks and reset
	input  wire logic                REF_CLK,
	input  wire logic                RST,
	input  wire logic                LINK_CLK,
	// Bus pins, open drain
	input  wire logic                SCL_I,
	output logic                     SCL_O,
	output logic                     SCL_OE_N,
	input  wire logic                SDA_I,
	output logic                     SDA_O,
	output logic                     SDA_OE_N,
	output logic                     FAULT_ALERT_OUT_O,
	output logic                     FAULT_ALERT_OUT_OE_N,
	// Address straps, decoded indexes
	input  wire logic [2:0]          ADDRESS_STRAP_LOW,
	input  wire logic [2:0]          ADDRESS_STRAP_HIGH,
	// Faults and telemetry
	input  wire logic [7:0]          FAULT_IN,
	input  wire logic                OUTPUT_REENABLE,
	input  wire pmti_pkg::pmti_word_t VIN,
	input  wire pmti_pkg::pmti_word_t VOUT,
	input  wire pmti_pkg::pmti_word_t IOUT,
	input  wire pmti_pkg::pmti_word_t TEMP_INT,
	input  wire pmti_pkg::pmti_word_t TEMP_EXT,
	input  wire pmti_pkg::pmti_word_t FREQ,
	input  wire pmti_pkg::pmti_word_t DUTY,
	// Status
	output logic                     BUSY,
	output logic [6:0]               ADDR_OUT
);
	import pmti_pkg::*;
	localparam int CFG_DEPTH = `PMTI_CFG_DEPTH;
	localparam int BW        = $clog2(STORE_CYC + 1);
	if (STORE_CYC < CFG_DEPTH) begin : g_chk
		$error("STORE_CYC must cover one pass over the config");
	end
	////////////////////////////////////////////////////////////////
	// Reference domain
	logic [5:0]    strap_s;
	logic [8:0]    addr_sum;
	logic          addr_ok;
	logic [6:0]    addr_reg;
	logic [6:0]    sent_reg;
	logic          a_busy;
	logic          q_pulse;
	logic [26:0]   q_data;
	logic          q_kind;
	logic [1:0]    q_nb;
	pmti_byte_t    q_cmd;
	pmti_word_t    q_dat;
	pmti_word_t    cfg_mem [CFG_DEPTH];
	pmti_word_t    otp_mem [CFG_DEPTH];
	logic          wr_go;
	logic          cfg_we;
	logic          clr_fault;
	logic          store_go;
	logic          rest_go;
	logic          busy;
	logic [BW-1:0] wait_reg;
	logic          cp_act_reg;
	logic          cp_st_reg;
	pmti_byte_t    cp_idx_reg;
	logic [7:0]    sticky_reg;
	logic          alert_reg;
	logic          reen_reg;
	pmti_byte_t    mask;
	logic          tsel;
	pmti_word_t    rd_word;
	logic          rp_v_reg;
	pmti_word_t    rp_d_reg;
	pmti_sync #(.W(6)) u_strap (
		.clk(REF_CLK),
		.d({ADDRESS_STRAP_HIGH, ADDRESS_STRAP_LOW}),
		.q(strap_s)
	);
	// Resolve address from straps and offset
	assign addr_sum = 9'(strap_s[5:3]) * `PMTI_STRAP_MULT + 9'(strap_s[2:0])
		+ 9'(cfg_mem[`PMTI_CMD_OFFSET][7:0]);
	assign addr_ok = addr_sum >= `PMTI_ADDR_MIN && addr_sum <= `PMTI_ADDR_MAX
		&& addr_sum != `PMTI_ADDR_BAD0 && addr_sum != `PMTI_ADDR_BAD1;
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			addr_reg <= `PMTI_ADDR_FALLBK;
		end else begin
			addr_reg <= addr_ok ? addr_sum[6:0] : `PMTI_ADDR_FALLBK;
		end
	end
	assign ADDR_OUT = addr_reg;
	// Push address changes to the link side
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			sent_reg <= 7'h00;
		end else if (!a_busy) begin
			sent_reg <= addr_reg;
		end
	end
	// Request decode
	assign q_kind    = q_data[26];
	assign q_nb      = q_data[25:24];
	assign q_cmd     = q_data[23:16];
	assign q_dat     = q_data[15:0];
	assign wr_go     = q_pulse && !q_kind;
	assign cfg_we    = wr_go && !busy && q_nb != 2'd1;
	assign clr_fault = (wr_go && q_nb == 2'd1 && q_cmd == `PMTI_CMD_CLEAR)
		|| (OUTPUT_REENABLE && !reen_reg);
	assign store_go  = wr_go && !busy && q_nb == 2'd1 && q_cmd == `PMTI_CMD_STORE;
	assign rest_go   = wr_go && !busy && q_nb == 2'd1 && q_cmd == `PMTI_CMD_RESTORE;
	assign busy      = wait_reg != '0 || cp_act_reg;
	assign BUSY      = busy;
	assign mask      = cfg_mem[`PMTI_CMD_MASK][7:0];
	assign tsel      = cfg_mem[`PMTI_CMD_TSEL][`PMTI_TSEL_BIT];
	// Working configuration, rewritable over the bus
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			for (int i = 0; i < CFG_DEPTH; i++) begin
				cfg_mem[i] <= `PMTI_CFG_RST;
			end
			cfg_mem[`PMTI_CMD_OFFSET] <= {8'h00, DEF_OFFSET};
		end else if (cp_act_reg && !cp_st_reg) begin
			cfg_mem[cp_idx_reg] <= otp_mem[cp_idx_reg];
		end else if (cfg_we) begin
			cfg_mem[q_cmd] <= (q_nb == 2'd3) ? q_dat : {8'h00, q_dat[7:0]};
		end
	end
	// User memory, written only by the store pass
	always_ff @(posedge REF_CLK) begin
		if (cp_act_reg && cp_st_reg) begin
			otp_mem[cp_idx_reg] <= cfg_mem[cp_idx_reg];
		end
	end
	// Copy pass and busy timer
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			wait_reg   <= '0;
			cp_act_reg <= 1'b0;
			cp_st_reg  <= 1'b0;
			cp_idx_reg <= 8'h00;
		end else if (store_go || rest_go) begin
			wait_reg   <= store_go ? BW'(STORE_CYC - 1) : BW'(CFG_DEPTH - 1);
			cp_act_reg <= 1'b1;
			cp_st_reg  <= store_go;
			cp_idx_reg <= 8'h00;
		end else begin
			if (wait_reg != '0) begin
				wait_reg <= wait_reg - BW'(1);
			end
			if (cp_act_reg) begin
				cp_idx_reg <= cp_idx_reg + 8'h01;
				cp_act_reg <= cp_idx_reg != 8'hff;
			end
		end
	end
	// Sticky faults, set wins over clear
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			sticky_reg <= 8'h00;
			alert_reg  <= 1'b0;
			reen_reg   <= 1'b0;
		end else begin
			sticky_reg <= (clr_fault ? 8'h00 : sticky_reg) | FAULT_IN;
			alert_reg  <= |(sticky_reg & ~mask);
			reen_reg   <= OUTPUT_REENABLE;
		end
	end
	assign FAULT_ALERT_OUT_O    = 1'b0;
	assign FAULT_ALERT_OUT_OE_N = ~alert_reg;
	// Read data select
	always_comb begin
		rd_word = cfg_mem[q_cmd];
		unique case (q_cmd)
			`PMTI_CMD_VIN:  rd_word = VIN;
			`PMTI_CMD_VOUT: rd_word = VOUT;
			`PMTI_CMD_IOUT: rd_word = IOUT;
			`PMTI_CMD_TEMP: rd_word = tsel ? TEMP_EXT : TEMP_INT;
			`PMTI_CMD_FREQ: rd_word = FREQ;
			`PMTI_CMD_DUTY: rd_word = DUTY;
			`PMTI_CMD_STAT_B, `PMTI_CMD_STAT_W: begin
				rd_word                  = 16'h0000;
				rd_word[`PMTI_BUSY_BIT]  = busy;
				rd_word[`PMTI_FAULT_BIT] = alert_reg;
			end
			default: rd_word = cfg_mem[q_cmd];
		endcase
	end
	// Reply register toward the link
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			rp_v_reg <= 1'b0;
			rp_d_reg <= 16'h0000;
		end else begin
			rp_v_reg <= q_pulse && q_kind;
			if (q_pulse && q_kind) begin
				rp_d_reg <= rd_word;
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// Link domain
	logic          link_rst;
	logic [1:0]    pin_s;
	logic          scl_s;
	logic          sda_s;
	logic          scl_q;
	logic          sda_q;
	logic          rise;
	logic          fall;
	logic          start;
	logic          stop;
	pmti_lst_e     st_reg;
	logic [3:0]    bcnt_reg;
	pmti_byte_t    sh_reg;
	pmti_byte_t    tx_reg;
	logic          rw_reg;
	logic          sda_dn_reg;
	logic          scl_dn_reg;
	logic [1:0]    nb_reg;
	pmti_byte_t    cmd_reg;
	pmti_word_t    dat_reg;
	logic          pend_reg;
	logic          rq_v_reg;
	logic [26:0]   rq_d_reg;
	logic [6:0]    my_addr_reg;
	logic          a_pulse;
	logic [6:0]    a_data;
	logic          rp_pulse;
	pmti_word_t    rp_data;
	pmti_sync #(.W(1)) u_rst (.clk(LINK_CLK), .d(RST), .q(link_rst));
	pmti_sync #(.W(2)) u_pin (.clk(LINK_CLK), .d({SCL_I, SDA_I}), .q(pin_s));
	assign scl_s = pin_s[1];
	assign sda_s = pin_s[0];
	// Line edges and bus conditions
	always_ff @(posedge LINK_CLK) begin
		if (link_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end
	assign rise  = scl_s && !scl_q;
	assign fall  = !scl_s && scl_q;
	assign start = scl_s && scl_q && sda_q && !sda_s;
	assign stop  = scl_s && scl_q && !sda_q && sda_s;
	// Own address from the reference side
	always_ff @(posedge LINK_CLK) begin
		if (link_rst) begin
			my_addr_reg <= `PMTI_ADDR_FALLBK;
		end else if (a_pulse) begin
			my_addr_reg <= a_data;
		end
	end
	// SMBus target engine
	always_ff @(posedge LINK_CLK) begin
		if (link_rst) begin
			st_reg     <= LS_IDLE;
			bcnt_reg   <= 4'h0;
			sh_reg     <= 8'h00;
			tx_reg     <= 8'hff;
			rw_reg     <= 1'b0;
			sda_dn_reg <= 1'b0;
			scl_dn_reg <= 1'b0;
			nb_reg     <= 2'd0;
			cmd_reg    <= 8'h00;
			dat_reg    <= 16'h0000;
			pend_reg   <= 1'b0;
			rq_v_reg   <= 1'b0;
			rq_d_reg   <= '0;
		end else begin
			rq_v_reg <= 1'b0;
			if (stop) begin
				st_reg     <= LS_IDLE;
				sda_dn_reg <= 1'b0;
				scl_dn_reg <= 1'b0;
				nb_reg     <= 2'd0;
				pend_reg   <= 1'b0;
				if (pend_reg) begin
					rq_v_reg <= 1'b1;
					rq_d_reg <= {1'b0, nb_reg, cmd_reg, dat_reg};
				end
			end else if (start) begin
				st_reg     <= LS_ADDR;
				bcnt_reg   <= 4'h0;
				sda_dn_reg <= 1'b0;
			end else begin
				unique case (st_reg)
					LS_IDLE, LS_SKIP: begin
						sda_dn_reg <= 1'b0;
					end
					LS_ADDR, LS_WRX: begin
						if (rise) begin
							sh_reg   <= {sh_reg[6:0], sda_s};
							bcnt_reg <= bcnt_reg + 4'h1;
						end else if (fall && bcnt_reg == 4'h8) begin
							if (st_reg == LS_WRX) begin
								sda_dn_reg <= 1'b1;
								st_reg     <= LS_WACK;
								pend_reg   <= 1'b1;
								nb_reg     <= (nb_reg == 2'd3) ? nb_reg : nb_reg + 2'd1;
								unique case (nb_reg)
									2'd0: cmd_reg <= sh_reg;
									2'd1: dat_reg[7:0] <= sh_reg;
									2'd2: dat_reg[15:8] <= sh_reg;
									2'd3: dat_reg <= dat_reg;
								endcase
							end else if (sh_reg[7:1] == my_addr_reg) begin
								sda_dn_reg <= 1'b1;
								rw_reg     <= sh_reg[0];
								st_reg     <= LS_WACK;
								if (sh_reg[0]) begin
									pend_reg <= 1'b0;
								end
							end else begin
								st_reg <= LS_SKIP;
							end
						end
					end
					LS_WACK: begin
						if (fall) begin
							sda_dn_reg <= 1'b0;
							bcnt_reg   <= 4'h0;
							if (rw_reg) begin
								scl_dn_reg <= 1'b1;
								rq_v_reg   <= 1'b1;
								rq_d_reg   <= {1'b1, nb_reg, cmd_reg, dat_reg};
								st_reg     <= LS_WAIT;
							end else begin
								st_reg <= LS_WRX;
							end
						end
					end
					LS_WAIT: begin
						if (rp_pulse) begin
							sh_reg     <= rp_data[7:0];
							tx_reg     <= rp_data[15:8];
							sda_dn_reg <= ~rp_data[7];
							st_reg     <= LS_REL;
						end
					end
					LS_REL: begin
						scl_dn_reg <= 1'b0;
						bcnt_reg   <= 4'h0;
						st_reg     <= LS_TX;
					end
					LS_TX: begin
						if (fall && bcnt_reg == 4'h7) begin
							sda_dn_reg <= 1'b0;
							st_reg     <= LS_RACK;
						end else if (fall) begin
							sh_reg     <= {sh_reg[6:0], 1'b0};
							sda_dn_reg <= ~sh_reg[6];
							bcnt_reg   <= bcnt_reg + 4'h1;
						end
					end
					LS_RACK: begin
						if (rise && sda_s) begin
							st_reg <= LS_SKIP;
						end else if (fall) begin
							sh_reg     <= tx_reg;
							tx_reg     <= 8'hff;
							sda_dn_reg <= ~tx_reg[7];
							bcnt_reg   <= 4'h0;
							st_reg     <= LS_TX;
						end
					end
				endcase
			end
		end
	end
	assign SCL_O    = 1'b0;
	assign SDA_O    = 1'b0;
	assign SCL_OE_N = ~scl_dn_reg;
	assign SDA_OE_N = ~sda_dn_reg;
	////////////////////////////////////////////////////////////////
	// Domain crossings
	pmti_hs #(.W(27)) u_rq (
		.s_clk(LINK_CLK), .s_rst(link_rst), .s_valid(rq_v_reg), .s_data(rq_d_reg),
		.s_busy(), .d_clk(REF_CLK), .d_rst(RST), .d_pulse(q_pulse), .d_data(q_data)
	);
	pmti_hs #(.W(16)) u_rp (
		.s_clk(REF_CLK), .s_rst(RST), .s_valid(rp_v_reg), .s_data(rp_d_reg),
		.s_busy(), .d_clk(LINK_CLK), .d_rst(link_rst), .d_pulse(rp_pulse), .d_data(rp_data)
	);
	pmti_hs #(.W(7)) u_ad (
		.s_clk(REF_CLK), .s_rst(RST), .s_valid(addr_reg != sent_reg), .s_data(addr_reg),
		.s_busy(a_busy), .d_clk(LINK_CLK), .d_rst(link_rst), .d_pulse(a_pulse), .d_data(a_data)
	);
	////////////////////////////////////////////////////////////////
	// Checks
	sequence s_reply;
		st_reg == LS_WAIT && rp_pulse && !stop && !start;
	endsequence
	sequence s_store;
		store_go;
	endsequence
	property p_addr_fallback;
		@(posedge REF_CLK) disable iff (RST) !addr_ok |=> addr_reg == `PMTI_ADDR_FALLBK;
	endproperty
	a_addr_fallback: assert property (p_addr_fallback) else $error("no fallback");
	property p_addr_sum;
		@(posedge REF_CLK) disable iff (RST) addr_ok |=> addr_reg == $past(addr_sum[6:0]);
	endproperty
	a_addr_sum: assert property (p_addr_sum) else $error("address sum wrong");
	property p_addr_range;
		@(posedge REF_CLK) disable iff (RST)
			addr_reg != 7'h00 && addr_reg != 7'h7f && addr_reg != 7'h0c && addr_reg != 7'h10;
	endproperty
	a_addr_range: assert property (p_addr_range) else $error("illegal address");
	property p_alert_set;
		@(posedge REF_CLK) disable iff (RST)
			(|(FAULT_IN & ~mask)) && $stable(mask) && !cfg_we && !cp_act_reg
			|-> ##2 !FAULT_ALERT_OUT_OE_N;
	endproperty
	a_alert_set: assert property (p_alert_set) else $error("alert missing");
	property p_alert_hold;
		@(posedge REF_CLK) disable iff (RST)
			$rose(FAULT_ALERT_OUT_OE_N) |-> $past(clr_fault, 2) || $past(cfg_we, 2)
			|| $past(cp_act_reg, 2);
	endproperty
	a_alert_hold: assert property (p_alert_hold) else $error("alert dropped");
	property p_mask_gate;
		@(posedge REF_CLK) disable iff (RST) (sticky_reg & ~mask) == 8'h00 |=> FAULT_ALERT_OUT_OE_N;
	endproperty
	a_mask_gate: assert property (p_mask_gate) else $error("masked alert");
	property p_busy_hold;
		@(posedge REF_CLK) disable iff (RST) s_store |=> BUSY [*8];
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("store not busy");
	property p_temp_sel;
		@(posedge REF_CLK) disable iff (RST) q_pulse && q_kind && q_cmd == `PMTI_CMD_TEMP
			|=> rp_d_reg == ($past(tsel) ? $past(TEMP_EXT) : $past(TEMP_INT));
	endproperty
	a_temp_sel: assert property (p_temp_sel) else $error("temperature source wrong");
	property p_stretch;
		@(posedge LINK_CLK) disable iff (link_rst)
			s_reply |-> !SCL_OE_N ##1 !SCL_OE_N ##1 SCL_OE_N;
	endproperty
	a_stretch: assert property (p_stretch) else $error("stretch release wrong");
	property p_foreign;
		@(posedge LINK_CLK) disable iff (link_rst) st_reg == LS_SKIP |=> SDA_OE_N;
	endproperty
	a_foreign: assert property (p_foreign) else $error("drove foreign traffic");
endmodule : pmti_target

// ---- verif/pmti_host.sv ----
// Purpose: Behavioural SMBus host for the PMBus target bench
// Assumes: Open-drain wires resolved by the bench with pull-ups
// Notes:   400 kHz bit rate; no packet error check bytes are sent
module pmti_host (
	// Resolved wires
	input  wire logic scl,
	input  wire logic sda,
	// Releases, high lets the pull-up win
	output logic      scl_rel,
	output logic      sda_rel
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int Q = 625; // Quarter bit at 400 kHz
	// Idle bus
	initial begin
		scl_rel = 1'b1;
		sda_rel = 1'b1;
	end
	// One bit; a clock held low by the target is waited out
	task automatic bit_io(input logic b, output logic r);
		int i;
		sda_rel = b;
		#Q;
		scl_rel = 1'b1;
		for (i = 0; i < 800 && scl !== 1'b1; i++) #125;
		#(2 * Q);
		r = sda;
		scl_rel = 1'b0;
		#Q;
	endtask : bit_io
	// Start or repeated start
	task automatic start;
		sda_rel = 1'b1;
		scl_rel = 1'b1;
		#Q;
		sda_rel = 1'b0;
		#Q;
		scl_rel = 1'b0;
		#Q;
	endtask : start
	// Stop, then bus-free time
	task automatic stop;
		sda_rel = 1'b0;
		#Q;
		scl_rel = 1'b1;
		#Q;
		sda_rel = 1'b1;
		#(8 * Q);
	endtask : stop
	// Byte out, MSB first; ack is low on the ninth bit
	task automatic byte_w(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = (r === 1'b0);
	endtask : byte_w
	// Byte in; last byte is answered with a nack
	task automatic byte_r(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask : byte_r
	// Send byte, byte or word write, low byte first
	task automatic wr(input logic [6:0] a, input logic [7:0] c, input int n,
		input logic [15:0] w, output logic ack);
		logic k;
		start();
		byte_w({a, 1'b0}, ack);
		byte_w(c, k);
		if (n > 0) byte_w(w[7:0], k);
		if (n > 1) byte_w(w[15:8], k);
		stop();
	endtask : wr
	// Read word with repeated start
	task automatic rd(input logic [6:0] a, input logic [7:0] c,
		output logic [15:0] w, output logic ack);
		logic k;
		start();
		byte_w({a, 1'b0}, ack);
		byte_w(c, k);
		start();
		byte_w({a, 1'b1}, k);
		byte_r(1'b0, w[7:0]);
		byte_r(1'b1, w[15:8]);
		stop();
	endtask : rd
endmodule : pmti_host

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench of the PMBus target
// Assumes: Host model drives the bus; bench drives straps and faults
// Notes:   Store time shortened through STORE_CYC
`include "pmti_defs.svh"
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import pmti_pkg::*;
	localparam int STORE_N = 4000; // Shortened store time
	logic ref_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] s_lo = 3'h3;
	logic [2:0] s_hi = 3'h2;
	logic [7:0] fault = 8'h00;
	logic reen = 1'b0;
	pmti_word_t tele [7];
	logic scl_rel, sda_rel, scl_oe_n, sda_oe_n, alert_n, busy, ack;
	logic [6:0] addr_out;
	logic [15:0] w;
	int n_fail = 0;
	int samples_checked = 0;
	// Open-drain wires with pull-ups
	wire scl = scl_rel & scl_oe_n;
	wire sda = sda_rel & sda_oe_n;
	// Clocks, unrelated in phase
	always #25 ref_clk = ~ref_clk;
	initial #37 forever #62.5 link_clk = ~link_clk;
	// Telemetry words, distinct per source
	initial for (int i = 0; i < 7; i++) tele[i] = 16'h1a2b + 16'(i) * 16'h1111;
	pmti_target #(.STORE_CYC(STORE_N)) uut (
		.REF_CLK(ref_clk), .RST(rst), .LINK_CLK(link_clk),
		.SCL_I(scl), .SCL_O(), .SCL_OE_N(scl_oe_n),
		.SDA_I(sda), .SDA_O(), .SDA_OE_N(sda_oe_n),
		.FAULT_ALERT_OUT_O(), .FAULT_ALERT_OUT_OE_N(alert_n),
		.ADDRESS_STRAP_LOW(s_lo), .ADDRESS_STRAP_HIGH(s_hi),
		.FAULT_IN(fault), .OUTPUT_REENABLE(reen),
		.VIN(tele[0]), .VOUT(tele[1]), .IOUT(tele[2]), .TEMP_INT(tele[3]),
		.TEMP_EXT(tele[4]), .FREQ(tele[5]), .DUTY(tele[6]),
		.BUSY(busy), .ADDR_OUT(addr_out));
	pmti_host host (.scl(scl), .sda(sda), .scl_rel(scl_rel), .sda_rel(sda_rel));
	// Compare and report
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Read word and compare ack and data
	task automatic rdc(input string nm, input logic [6:0] a, input logic [7:0] c,
		input logic [15:0] e);
		host.rd(a, c, w, ack);
		chk(nm, 16'h0001, 16'(ack));
		chk(nm, e, w);
	endtask : rdc
	// Change straps, let them resolve and reach the link
	task automatic straps(input logic [2:0] h, input logic [2:0] l);
		@(negedge ref_clk);
		s_hi = h;
		s_lo = l;
		#2000;
	endtask : straps
	// Raise one fault for a few cycles
	task automatic pulse;
		@(negedge ref_clk);
		fault = 8'h01;
		repeat (3) @(negedge ref_clk);
		fault = 8'h00;
		repeat (3) @(negedge ref_clk);
	endtask : pulse
	// Verdict and end of run
	task automatic give_verdict;
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : give_verdict
	// Watchdog
	initial begin
		#4500000;
		n_fail++;
		give_verdict();
	end
	// Main sequence
	initial begin
		static logic [12:0] tb [7] = '{{3'h1, 3'h3, 7'h0b}, {3'h1, 3'h4, 7'h7e},
			{3'h1, 3'h5, 7'h0d}, {3'h2, 3'h0, 7'h7e}, {3'h0, 3'h0, 7'h7e},
			{3'h0, 3'h1, 7'h01}, {3'h7, 3'h7, 7'h3f}};
		static logic [7:0] rc [6] = '{`PMTI_CMD_VIN, `PMTI_CMD_VOUT, `PMTI_CMD_IOUT,
			`PMTI_CMD_TEMP, `PMTI_CMD_DUTY, `PMTI_CMD_FREQ};
		static int ri [6] = '{0, 1, 2, 3, 6, 5};
		repeat (6) @(posedge link_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk("addr", 16'h0013, 16'(addr_out));
		foreach (tb[i]) begin
			straps(tb[i][12:10], tb[i][9:7]);
			chk("addr_tbl", 16'(tb[i][6:0]), 16'(addr_out));
		end
		straps(3'h2, 3'h3);
		host.wr(7'h14, 8'h40, 2, 16'h1234, ack);
		chk("foreign_ack", 16'h0000, 16'(ack));
		rdc("foreign_ignored", 7'h13, 8'h40, 16'h0000);
		host.wr(7'h13, 8'h40, 2, 16'hbeef, ack);
		rdc("cfg_word", 7'h13, 8'h40, 16'hbeef);
		host.wr(7'h13, 8'h41, 1, 16'hff77, ack);
		rdc("cfg_byte", 7'h13, 8'h41, 16'h0077);
		foreach (rc[i]) rdc("tele", 7'h13, rc[i], tele[ri[i]]);
		host.wr(7'h13, `PMTI_CMD_TSEL, 1, 16'h0001, ack);
		rdc("temp_ext", 7'h13, `PMTI_CMD_TEMP, tele[4]);
		host.wr(7'h13, `PMTI_CMD_OFFSET, 1, 16'h0040, ack);
		@(negedge ref_clk);
		chk("addr_off", 16'h0053, 16'(addr_out));
		straps(3'h7, 3'h5);
		chk("addr_125", 16'h007d, 16'(addr_out));
		straps(3'h7, 3'h7);
		chk("addr_127", 16'h007e, 16'(addr_out));
		rdc("at_fallback", 7'h7e, 8'h40, 16'hbeef);
		host.wr(7'h7e, `PMTI_CMD_OFFSET, 1, 16'h0000, ack);
		pulse();
		chk("alert_set", 16'h0000, 16'(alert_n));
		host.rd(7'h3f, `PMTI_CMD_STAT_W, w, ack);
		chk("stat_alert", 16'h0001, 16'(w[`PMTI_FAULT_BIT]));
		host.wr(7'h3f, `PMTI_CMD_CLEAR, 0, 16'h0000, ack);
		@(negedge ref_clk);
		chk("alert_clr", 16'h0001, 16'(alert_n));
		host.wr(7'h3f, `PMTI_CMD_MASK, 1, 16'h0001, ack);
		pulse();
		chk("alert_mask", 16'h0001, 16'(alert_n));
		host.wr(7'h3f, `PMTI_CMD_MASK, 1, 16'h0000, ack);
		@(negedge ref_clk);
		chk("alert_unmask", 16'h0000, 16'(alert_n));
		@(negedge ref_clk);
		reen = 1'b1;
		repeat (3) @(negedge ref_clk);
		chk("alert_reen", 16'h0001, 16'(alert_n));
		reen = 1'b0;
		host.wr(7'h3f, `PMTI_CMD_STORE, 0, 16'h0000, ack);
		@(negedge ref_clk);
		chk("busy_store", 16'h0001, 16'(busy));
		host.rd(7'h3f, `PMTI_CMD_STAT_B, w, ack);
		chk("stat_busy", 16'h0001, 16'(w[`PMTI_BUSY_BIT]));
		for (int i = 0; i < STORE_N && busy === 1'b1; i++) @(negedge ref_clk);
		chk("busy_done", 16'h0000, 16'(busy));
		repeat (STORE_N) @(negedge ref_clk);
		host.rd(7'h3f, `PMTI_CMD_STAT_B, w, ack);
		chk("stat_idle", 16'h0000, 16'(w[`PMTI_BUSY_BIT]));
		rdc("cfg_kept", 7'h3f, 8'h40, 16'hbeef);
		// Overwrite, then bring the stored word back from user memory
		host.wr(7'h3f, 8'h40, 2, 16'h1111, ack);
		rdc("cfg_over", 7'h3f, 8'h40, 16'h1111);
		host.wr(7'h3f, `PMTI_CMD_RESTORE, 0, 16'h0000, ack);
		repeat (`PMTI_CFG_DEPTH) @(negedge ref_clk);
		rdc("cfg_restored", 7'h3f, 8'h40, 16'hbeef);
		give_verdict();
	end
endmodule : testbench
